// *** clock_edge_tracker.sv ***
/*
  Two-flop synchroniser plus rising-edge finder for one foreign clock.
  Assumes the sampled clock runs well below half the hclk rate.
*/
`timescale 1ns/1ps

module clock_edge_tracker (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic ce,
  input  wire logic raw_clk,
  output logic      level,
  output logic      rise
);

  logic meta_reg;
  logic meta_next;
  logic sync_reg;
  logic sync_next;
  logic prev_reg;
  logic prev_next;

  // ============================================================
  // Synchroniser and edge history
  always_comb begin
    meta_next = ce ? raw_clk  : meta_reg;
    sync_next = ce ? meta_reg : sync_reg;
    prev_next = ce ? sync_reg : prev_reg;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      prev_reg <= prev_next;
    end
  end

  assign level = sync_reg;
  assign rise  = sync_reg & ~prev_reg;

endmodule : clock_edge_tracker

// *** clock_select_defs.svh ***
/*
  Offsets, field positions, reset values and counts for the clock selector.
  Assumes a 32-bit AHB-Lite register window with one word per register.
*/
`ifndef CLOCK_SELECT_DEFS_SVH
`define CLOCK_SELECT_DEFS_SVH

// ============================================================
// Register offsets (byte addresses)
`define CSEL_CTRL_OFS        12'h000
`define CSEL_STATUS_OFS      12'h004

// ============================================================
// Control register fields
`define CSEL_CTRL_SELECT     0
`define CSEL_CTRL_FORCE      1
`define CSEL_CTRL_HOLD       2
`define CSEL_CTRL_PARK       3
`define CSEL_CTRL_SLEEP_N    4
`define CSEL_CTRL_WIDTH      5
`define CSEL_CTRL_RESET      5'h11

// ============================================================
// Status register fields
`define CSEL_STAT_ACTIVE     0
`define CSEL_STAT_BUSY       1
`define CSEL_STAT_DRAIN      2
`define CSEL_STAT_OUT        3

// ============================================================
// Switchover timing and fanout
`define CSEL_HOLD_RISES      2'h2
`define CSEL_FANOUT          6

`endif

// *** clock_select_pkg.sv ***
/*
  Types shared by the clock selector modules.
  Assumes nothing beyond the constants header.
*/
package clock_select_pkg;

  typedef enum logic [1:0] {
    SW_RUN,
    SW_DRAIN,
    SW_HOLD
  } sw_state_t;

endpackage : clock_select_pkg

// *** glitchless_clock_select_fanout.sv ***
/*
  Glitchless two-way clock selector with six gated differential outputs,
  controlled over AHB-Lite.
  Assumes both reference clocks reach hclk as asynchronous pins and run
  below half the hclk rate; the bus master issues single word transfers.
*/
// Operation
// - On a new choice, outputs go low within three cycles of the old clock.
// - Outputs stay low at most three new-clock cycles, then follow cleanly.
// - Select low routes the second input clock, high routes the first.
// - Output hold high parks all outputs at the park level, ignoring clocks.
// - Output hold low lets all six pairs toggle with the selected clock.
// - Park level high: true high, complement low; low: the reverse.
// - Sleep low overrides the outputs and drives both sides high; inputs and switchover keep running.
// - A rising edge on the forced-choice strobe forces the selection now.
// - Switching by select stays glitch free across the supported input rates; a forced choice drops the outputs low at once.
// - The selected clock fans out to six identical differential pairs.
`timescale 1ns/1ps
`include "clock_select_defs.svh"

module glitchless_clock_select_fanout (
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire logic                   ce,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic      [31:0]            hrdata,
  output logic                        hreadyout,
  output logic                        hresp,
  input  wire logic                   clk_first,
  input  wire logic                   clk_second,
  output logic [`CSEL_FANOUT-1:0]     q_true,
  output logic [`CSEL_FANOUT-1:0]     q_comp
);
  import clock_select_pkg::*;

  // ============================================================
  // Reference clock sampling
  logic [1:0] ref_lvl;
  logic [1:0] ref_rise;
  logic [1:0] ref_raw;

  assign ref_raw = {clk_first, clk_second};

  // Each input clock gets its own synchroniser before any decision.
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ref
      clock_edge_tracker u_track (
        .hclk    (hclk),
        .hresetn (hresetn),
        .ce      (ce),
        .raw_clk (ref_raw[gi]),
        .level   (ref_lvl[gi]),
        .rise    (ref_rise[gi])
      );
    end
  endgenerate

  // ============================================================
  // AHB-Lite slave
  logic                        ph_valid_reg, ph_valid_next;
  logic                        ph_write_reg, ph_write_next;
  logic [11:0]                 ph_addr_reg,  ph_addr_next;
  logic [31:0]                 hrdata_reg,   hrdata_next;
  logic [`CSEL_CTRL_WIDTH-1:0] ctrl_reg,     ctrl_next;
  logic [`CSEL_CTRL_WIDTH-1:0] ctrl_view;
  logic [31:0]                 status_word;
  logic                        addr_take;

  // Freezing ce also stalls the bus, so no transfer is lost.
  assign hreadyout = ce;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_reg;
  assign addr_take = ce & hready & hsel & htrans[1];

  // A read right behind a write sees the written value.
  always_comb begin
    ctrl_view = ctrl_reg;
    if (ce && ph_valid_reg && ph_write_reg && ph_addr_reg == `CSEL_CTRL_OFS) begin
      ctrl_view = hwdata[`CSEL_CTRL_WIDTH-1:0];
    end
  end

  always_comb begin
    ph_valid_next = ph_valid_reg;
    ph_write_next = ph_write_reg;
    ph_addr_next  = ph_addr_reg;
    hrdata_next   = hrdata_reg;
    ctrl_next     = ctrl_view;
    if (ce && hready) begin
      ph_valid_next = addr_take;
      ph_write_next = hwrite;
      ph_addr_next  = {haddr[11:2], 2'b00};
      if (addr_take && !hwrite) begin
        unique case ({haddr[11:2], 2'b00})
          `CSEL_CTRL_OFS:   hrdata_next = {27'h0000000, ctrl_view};
          `CSEL_STATUS_OFS: hrdata_next = status_word;
          default:          hrdata_next = 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_valid_reg <= 1'b0;
      ph_write_reg <= 1'b0;
      ph_addr_reg  <= 12'h000;
      hrdata_reg   <= 32'h00000000;
      ctrl_reg     <= `CSEL_CTRL_RESET;
    end else begin
      ph_valid_reg <= ph_valid_next;
      ph_write_reg <= ph_write_next;
      ph_addr_reg  <= ph_addr_next;
      hrdata_reg   <= hrdata_next;
      ctrl_reg     <= ctrl_next;
    end
  end

  logic sel_req, force_lvl, hold_ctl, park_lvl, sleep_n;
  assign sel_req   = ctrl_reg[`CSEL_CTRL_SELECT];
  assign force_lvl = ctrl_reg[`CSEL_CTRL_FORCE];
  assign hold_ctl  = ctrl_reg[`CSEL_CTRL_HOLD];
  assign park_lvl  = ctrl_reg[`CSEL_CTRL_PARK];
  assign sleep_n   = ctrl_reg[`CSEL_CTRL_SLEEP_N];

  // ============================================================
  // Switchover engine
  sw_state_t  state_reg,  state_next;
  logic       active_reg, active_next;
  logic       out_reg,    out_next;
  logic [1:0] rises_reg,  rises_next;
  logic       force_prev_reg, force_prev_next;
  logic       force_rise;
  logic       old_lvl, new_lvl, new_rise;

  // Select high picks the first clock, low the second.
  assign old_lvl    = active_reg ? ref_lvl[1] : ref_lvl[0];
  assign new_lvl    = active_reg ? ref_lvl[1] : ref_lvl[0];
  assign new_rise   = active_reg ? ref_rise[1] : ref_rise[0];
  // Strobe is assumed idle low out of reset, so no edge is seen then.
  assign force_rise = force_lvl & ~force_prev_reg;

  always_comb begin
    state_next      = state_reg;
    active_next     = active_reg;
    out_next        = out_reg;
    rises_next      = rises_reg;
    force_prev_next = force_prev_reg;
    if (ce) begin
      force_prev_next = force_lvl;
      if (force_rise) begin
        // Skips the drain: the old clock may be dead or stuck.
        active_next = sel_req;
        state_next  = SW_HOLD;
        rises_next  = 2'h0;
        out_next    = 1'b0;
      end else begin
        unique case (state_reg)
          SW_RUN: begin
            out_next = new_lvl;
            if (sel_req != active_reg) begin
              state_next = SW_DRAIN;
            end
          end
          SW_DRAIN: begin
            // Let the current high phase finish, then park low.
            if (!old_lvl) begin
              out_next    = 1'b0;
              active_next = sel_req;
              rises_next  = 2'h0;
              state_next  = SW_HOLD;
            end else begin
              out_next = old_lvl;
            end
          end
          SW_HOLD: begin
            out_next = 1'b0;
            if (new_rise && rises_reg != `CSEL_HOLD_RISES) begin
              rises_next = rises_reg + 2'h1;
            end
            // Release only in a low phase so the first pulse is whole.
            if (rises_reg == `CSEL_HOLD_RISES && !new_lvl) begin
              state_next = SW_RUN;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg      <= SW_RUN;
      active_reg     <= 1'b1;
      out_reg        <= 1'b0;
      rises_reg      <= 2'h0;
      force_prev_reg <= 1'b0;
    end else begin
      state_reg      <= state_next;
      active_reg     <= active_next;
      out_reg        <= out_next;
      rises_reg      <= rises_next;
      force_prev_reg <= force_prev_next;
    end
  end

  assign status_word = {28'h0000000, out_reg, (state_reg == SW_DRAIN),
                        (state_reg != SW_RUN), active_reg};

  // ============================================================
  // Output gating and fanout
  logic [`CSEL_FANOUT-1:0] qt_reg, qt_next, qc_reg, qc_next;

  // Gating is level based; runts at gate changes are the controller's concern.
  always_comb begin
    qt_next = qt_reg;
    qc_next = qc_reg;
    if (ce) begin
      if (!sleep_n) begin
        qt_next = {`CSEL_FANOUT{1'b1}};
        qc_next = {`CSEL_FANOUT{1'b1}};
      end else if (hold_ctl) begin
        qt_next = {`CSEL_FANOUT{park_lvl}};
        qc_next = {`CSEL_FANOUT{~park_lvl}};
      end else begin
        qt_next = {`CSEL_FANOUT{out_reg}};
        qc_next = {`CSEL_FANOUT{~out_reg}};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      qt_reg <= {`CSEL_FANOUT{1'b0}};
      qc_reg <= {`CSEL_FANOUT{1'b1}};
    end else begin
      qt_reg <= qt_next;
      qc_reg <= qc_next;
    end
  end

  assign q_true = qt_reg;
  assign q_comp = qc_reg;

  // ============================================================
  // Assertions
  property p_drain_ends;
    @(posedge hclk) disable iff (!hresetn)
    (ce && state_reg == SW_DRAIN && !old_lvl && !force_rise)
      |=> (state_reg == SW_HOLD && !out_reg);
  endproperty
  a_drain_ends: assert property (p_drain_ends) else $error("drain did not end low");

  property p_hold_low;
    @(posedge hclk) disable iff (!hresetn)
    (state_reg == SW_HOLD) |=> !out_reg;
  endproperty
  a_hold_low: assert property (p_hold_low) else $error("output high during hold");

  property p_hold_release;
    @(posedge hclk) disable iff (!hresetn)
    (ce && state_reg == SW_HOLD && rises_reg == 2'h2 && !new_lvl && !force_rise)
      |=> (state_reg == SW_RUN);
  endproperty
  a_hold_release: assert property (p_hold_release) else $error("hold not released");

  property p_route;
    @(posedge hclk) disable iff (!hresetn)
    (ce && state_reg == SW_RUN && !force_rise)
      |=> (out_reg == ($past(active_reg) ? $past(ref_lvl[1]) : $past(ref_lvl[0])));
  endproperty
  a_route: assert property (p_route) else $error("wrong clock routed");

  property p_park;
    @(posedge hclk) disable iff (!hresetn)
    (ce && sleep_n && hold_ctl) |=> (q_true == {6{$past(park_lvl)}});
  endproperty
  a_park: assert property (p_park) else $error("park level not applied");

  property p_toggle;
    @(posedge hclk) disable iff (!hresetn)
    (ce && sleep_n && !hold_ctl) |=> (q_true == {6{$past(out_reg)}});
  endproperty
  a_toggle: assert property (p_toggle) else $error("outputs not following clock");

  property p_complement;
    @(posedge hclk) disable iff (!hresetn)
    (ce && sleep_n) |=> (q_comp == ~q_true);
  endproperty
  a_complement: assert property (p_complement) else $error("pair not complementary");

  property p_sleep;
    @(posedge hclk) disable iff (!hresetn)
    (ce && !sleep_n) |=> (&q_true && &q_comp);
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep outputs not high");

  property p_force;
    @(posedge hclk) disable iff (!hresetn)
    (ce && force_rise) |=> (state_reg == SW_HOLD && active_reg == $past(sel_req));
  endproperty
  a_force: assert property (p_force) else $error("forced choice not taken");

  property p_start;
    @(posedge hclk) disable iff (!hresetn)
    (ce && state_reg == SW_RUN && sel_req != active_reg && !force_rise)
      |=> (state_reg == SW_DRAIN);
  endproperty
  a_start: assert property (p_start) else $error("switchover not started");

endmodule : glitchless_clock_select_fanout

// *** glitchless_clock_select_fanout_test.sv ***
/*
  Self-checking bench for the clock selector: AHB-Lite tasks and output watchers.
  Assumes the reference clock model and the constants header.
*/
`timescale 1ns/1ps
`include "clock_select_defs.svh"

module glitchless_clock_select_fanout_test;
  import clock_select_pkg::*;
  localparam logic [31:0] CTRL_A = {20'h0, `CSEL_CTRL_OFS};
  localparam logic [31:0] STAT_A = {20'h0, `CSEL_STATUS_OFS};

  logic        hclk = 1'b0;
  logic        hresetn, ce, hwrite, hreadyout, hresp;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rdata;
  logic [5:0]  q_true, q_comp;
  logic        clk_first, clk_second, stop_first, stop_second, stuck_level;
  int          miscompares = 0;
  int          total_checks = 0;

  always #25 hclk = ~hclk;

  glitchless_clock_select_fanout u_dut (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .clk_first(clk_first), .clk_second(clk_second), .q_true(q_true), .q_comp(q_comp)
  );

  ref_clock_source u_src (
    .stop_first(stop_first), .stop_second(stop_second), .stuck_level(stuck_level),
    .clk_first(clk_first), .clk_second(clk_second)
  );

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  // ============================================================
  // Bus access: address phase held until hready, then data phase
  task automatic bus(input logic wr_en, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= wr_en;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdata = hrdata;
    check("hresp", 32'h0, {31'h0, hresp});
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [31:0] a);
    bus(1'b0, a, 32'h0);
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask : settle

  task automatic park_check(input logic [5:0] t, input logic [5:0] c);
    settle(3);
    check("q_true", {26'h0, t}, {26'h0, q_true});
    check("q_comp", {26'h0, c}, {26'h0, q_comp});
  endtask : park_check

  // Six pairs must move together and stay complementary
  task automatic watch_toggle(input string what);
    int hi, lo, bad;
    hi = 0;
    lo = 0;
    bad = 0;
    repeat (48) begin
      settle(1);
      if (q_true === 6'h3F) hi++;
      else if (q_true === 6'h00) lo++;
      else bad++;
      if (q_comp !== ~q_true) bad++;
    end
    check({what, " toggling"}, 32'h1, {31'h0, hi > 0 && lo > 0});
    check({what, " pairing"}, 32'h0, 32'(bad));
  endtask : watch_toggle

  // Clock enable low must freeze q_true while the references run on
  task automatic watch_frozen;
    int moves;
    logic [5:0] last;
    moves = 0;
    last = q_true;
    repeat (12) begin
      settle(1);
      if (q_true !== last) moves++;
      last = q_true;
    end
    check("stall frozen", 32'h0, 32'(moves));
  endtask : watch_frozen

  // Switchover: the long low span starts soon after the write, and is bounded
  task automatic switch_to(input logic s);
    int n, run, low_start, max_low, min_high;
    logic prev;
    wr(CTRL_A, {31'h8, s});
    prev = q_true[0];
    run = 0;
    low_start = -1;
    max_low = 0;
    min_high = 99;
    for (n = 0; n < 160; n++) begin
      settle(1);
      if (q_true[0] !== prev) begin
        if (prev === 1'b0 && run > max_low) begin
          max_low = run;
          low_start = n - run;
        end
        if (prev === 1'b1 && run < min_high && run < n) min_high = run;
        run = 0;
      end
      run++;
      prev = q_true[0];
    end
    check("old clock stop", 32'h1, {31'h0, low_start >= 0 && low_start <= 28});
    check("low span", 32'h1, {31'h0, max_low >= 12 && max_low <= 32});
    check("high width", 32'h1, {31'h0, min_high >= 3});
    rd(STAT_A);
    check("status after switch", {31'h0, s}, rdata & 32'h7);
  endtask : switch_to

  initial begin
    hresetn = 1'b0;
    ce = 1'b1;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    stop_first = 1'b0;
    stop_second = 1'b0;
    stuck_level = 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    rd(CTRL_A);
    check("ctrl reset", 32'h11, rdata);
    rd(STAT_A);
    check("status reset", 32'h1, rdata & 32'h7);
    rd(32'h8);
    check("unmapped read", 32'h0, rdata);
    wr(32'h8, 32'h1F);
    rd(CTRL_A);
    check("ctrl kept", 32'h11, rdata);
    $display("test registers done");
    stop_second <= 1'b1;
    watch_toggle("first routed");
    stop_second <= 1'b0;
    wr(CTRL_A, 32'h15);
    park_check(6'h00, 6'h3F);
    wr(CTRL_A, 32'h1D);
    park_check(6'h3F, 6'h00);
    wr(CTRL_A, 32'h19);
    watch_toggle("park high released");
    $display("test gating done");
    switch_to(1'b0);
    stop_first <= 1'b1;
    watch_toggle("second routed");
    stop_first <= 1'b0;
    switch_to(1'b1);
    switch_to(1'b0);
    $display("test switchover done");
    stuck_level <= 1'b1;
    stop_second <= 1'b1;
    wr(CTRL_A, 32'h11);
    settle(40);
    rd(STAT_A);
    check("stuck drain", 32'h6, rdata & 32'h6);
    wr(CTRL_A, 32'h13);
    wr(CTRL_A, 32'h11);
    settle(60);
    rd(STAT_A);
    check("forced choice", 32'h1, rdata & 32'h3);
    stop_second <= 1'b0;
    watch_toggle("after force");
    $display("test force done");
    wr(CTRL_A, 32'h15);
    wr(CTRL_A, 32'h05);
    park_check(6'h3F, 6'h3F);
    wr(CTRL_A, 32'h15);
    park_check(6'h00, 6'h3F);
    wr(CTRL_A, 32'h11);
    watch_toggle("awake");
    $display("test sleep done");
    @(posedge hclk);
    ce <= 1'b0;
    settle(2);
    check("stall ready", 32'h0, {31'h0, hreadyout});
    watch_frozen();
    @(posedge hclk);
    ce <= 1'b1;
    rd(CTRL_A);
    check("ctrl after stall", 32'h11, rdata);
    $display("test stall done");
    final_report();
  end

  // Hang guard, about ten times the expected run length
  initial begin
    #500000;
    miscompares++;
    final_report();
  end
endmodule : glitchless_clock_select_fanout_test

// *** ref_clock_source.sv ***
/*
  Model of the two reference clock sources at the selector's far side.
  Assumes the bench may freeze either source at a chosen level.
*/
`timescale 1ns/1ps

module ref_clock_source (
  input  wire logic stop_first,
  input  wire logic stop_second,
  input  wire logic stuck_level,
  output logic      clk_first,
  output logic      clk_second
);
  // ============================================================
  // Free-running sources, 400 ns period, second offset in phase
  logic run_first  = 1'b0;
  logic run_second = 1'b0;

  always #200 run_first = ~run_first;

  initial begin
    #130;
    forever #200 run_second = ~run_second;
  end

  // ============================================================
  // Frozen source stands for a dead or stuck reference
  assign clk_first  = stop_first ? stuck_level : run_first;
  assign clk_second = stop_second ? stuck_level : run_second;
endmodule : ref_clock_source
